// [dv/des_ctl_model.sv]
// Remote controller model: queries and commands as one-cycle strobes.
// Assumes the block samples them on the rising ref_clk edge.
`timescale 1ns/1ps
module des_ctl_model (
    // Clock
    input  wire logic   ref_clk,
    // Command strobes
    output logic        clear_status,
    output logic        device_event_status_rd,
    output logic        fault_rd,
    output logic        mask_wr,
    output logic [15:0] mask_wdata
);
    initial begin
        {clear_status, device_event_status_rd, fault_rd, mask_wr} = 4'h0;
        mask_wdata = 16'h5a5a;
    end
    // op: 0 clear status, 1 event query, 2 fault query, 3 mask write
    task automatic send(input int op, input logic [15:0] d);
        @(negedge ref_clk);
        mask_wdata = d;
        {clear_status, device_event_status_rd, fault_rd, mask_wr} = 4'h8 >> op;
        @(negedge ref_clk);
        {clear_status, device_event_status_rd, fault_rd, mask_wr} = 4'h0;
        // Data means nothing once the strobe drops, so scramble it
        mask_wdata = ~d;
    endtask
endmodule

// [dv/des_status_properties.sv]
// Checker for the event latch, mask, summary bit and fault latch.
// Sees only des_status ports; bound in from the testbench top.
`timescale 1ns/1ps
module des_status_properties
    import des_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // Sources
    input wire logic        compare_above,
    input wire logic        measure_done,
    input wire logic        overload,
    // Commands
    input wire logic        clear_status,
    input wire logic        device_event_status_rd,
    input wire logic        fault_rd,
    input wire logic        mask_wr,
    input wire logic [15:0] mask_wdata,
    // Readback
    input wire logic [15:0] device_event_status,
    input wire logic [15:0] fault_status,
    input wire logic [15:0] device_event_mask,
    input wire logic        device_summary_bit
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Nothing may clear the latch while an event waits to be read
    sequence above_wait_s;
        compare_above ##1
            (!clear_status && !device_event_status_rd)[*4] ##1
            device_event_status_rd;
    endsequence
    sequence fault_twice_s;
        fault_rd && !clear_status ##1 !clear_status ##1 fault_rd;
    endsequence

    spare_bits_a:
    assert property (device_event_status[3] == 1'b0 &&
        fault_status[8] == 1'b0 && fault_status[11] == 1'b0)
        else $error("spare status bit set");
    mask_load_a:
    assert property (mask_wr |=> device_event_mask == $past(mask_wdata))
        else $error("mask not loaded");
    mask_hold_a:
    assert property (!mask_wr |=> $stable(device_event_mask))
        else $error("mask changed without write");
    above_latched_a:
    assert property (above_wait_s |=> device_event_status[0])
        else $error("above event lost before read");
    summary_set_a:
    assert property (measure_done && device_event_mask[15] && !mask_wr
        |-> ##2 device_summary_bit) else $error("summary bit not raised");
    fault_keep_a:
    assert property (fault_twice_s |=>
        (fault_status & $past(fault_status)) == $past(fault_status))
        else $error("fault read lost bits");
    fault_stands_a:
    assert property (!fault_rd |=> $stable(fault_status))
        else $error("fault readback moved");
    overload_sticky_a:
    assert property (overload ##1 !clear_status ##1 fault_rd
        |=> fault_status[3]) else $error("overload bit not latched");
endmodule

// [dv/tb_des_status.sv]
// Self-checking bench for the event and fault status block.
// Sources change at the falling edge; the controller model sends commands.
`timescale 1ns/1ps
module tb_des_status;
    import des_pkg::*;
    logic ref_clk = 1'b0, rstn = 1'b0;
    logic hold_trigger_mode = 1'b1, burst_mode = 1'b0;
    logic [15:0] ev = 16'h0000, ft = 16'h0000, st = 16'h0000;
    int n_mismatch = 0, check_count = 0;
    wire compare_above = ev[0], compare_pass = ev[1], compare_under = ev[2],
        store_count_reached = ev[4], paused_state = ev[5],
        limiter_bottom = ev[6], limiter_top = ev[7],
        external_output_cut = ev[8], external_trigger_seen = ev[9],
        buffer_full_flag = ev[10], output_active = ev[11],
        calibration_done = ev[12], sequence_finished = ev[13],
        step_finished = ev[14], measure_done = ev[15];
    wire post_fail = ft[0], test_fail = ft[1], cal_data_lost = ft[2],
        overload = ft[3], fan_stop = ft[4], overheat = ft[5],
        source_fault = ft[6], param_lost = ft[7], flash_fail = ft[8],
        calc_error = ft[9], over_range = ft[10], cmd_arg_error = ft[12],
        cmd_exec_error = ft[13], cmd_format_error = ft[14],
        cmd_unknown = ft[15];
    wire calibration_start = st[0], sequence_start = st[1],
        step_start = st[2], step_resume = st[3], measure_start = st[4],
        measure_readout = st[5];
    wire clear_status, device_event_status_rd, fault_rd, mask_wr;
    wire [15:0] mask_wdata;
    logic [15:0] device_event_status, fault_status, device_event_mask;
    logic device_summary_bit;
    des_out_state_t out_state;

    des_status u_dut (.*);
    des_ctl_model u_ctl (.*);

    initial forever #5 ref_clk = ~ref_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic pulse(ref logic [15:0] v, input int k);
        @(negedge ref_clk);
        v[k] = 1'b1;
        @(negedge ref_clk);
        v[k] = 1'b0;
    endtask
    task automatic t_latch();
        for (int k = 0; k < 16; k++) begin
            if (k == 3 || k == 5 || k == 10 || k == 11) continue;
            pulse(ev, k);
            repeat (3) @(negedge ref_clk);
            u_ctl.send(1, 16'h0000);
            check(device_event_status, 16'h0001 << k);
            u_ctl.send(1, 16'h0000);
            check(device_event_status, 16'h0000);
        end
    endtask
    task automatic t_levels();
        int lv[3] = '{5, 10, 11};
        des_out_state_t ost[3] = '{DES_PAUSED, DES_IDLE, DES_ACTIVE};
        for (int i = 0; i < 3; i++) begin
            @(negedge ref_clk);
            ev[lv[i]] = 1'b1;
            u_ctl.send(1, 16'h0000);
            check(device_event_status, 16'h0001 << lv[i]);
            check({14'h0000, out_state}, {14'h0000, ost[i]});
            u_ctl.send(1, 16'h0000);
            check(device_event_status, 16'h0001 << lv[i]);
            ev[lv[i]] = 1'b0;
            u_ctl.send(1, 16'h0000);
            check(device_event_status, 16'h0000);
            check({14'h0000, out_state}, {14'h0000, DES_IDLE});
        end
    endtask
    task automatic t_starts();
        int sb[6] = '{12, 13, 14, 14, 15, 15};
        for (int i = 0; i < 6; i++) begin
            pulse(ev, sb[i]);
            pulse(st, i);
            u_ctl.send(1, 16'h0000);
            check(device_event_status, 16'h0000);
        end
    endtask
    task automatic t_modes();
        burst_mode = 1'b1;
        pulse(ev, 14);
        u_ctl.send(1, 16'h0000);
        check(device_event_status, 16'h0000);
        burst_mode = 1'b0;
        hold_trigger_mode = 1'b0;
        pulse(ev, 14);
        u_ctl.send(1, 16'h0000);
        check(device_event_status, 16'h0000);
        hold_trigger_mode = 1'b1;
    endtask
    task automatic t_summary();
        u_ctl.send(3, 16'h8000);
        check(device_event_mask, 16'h8000);
        pulse(ev, 0);
        repeat (2) @(negedge ref_clk);
        check({15'h0000, device_summary_bit}, 16'h0000);
        pulse(ev, 15);
        repeat (2) @(negedge ref_clk);
        check({15'h0000, device_summary_bit}, 16'h0001);
        u_ctl.send(1, 16'h0000);
        check(device_event_status, 16'h8001);
        @(negedge ref_clk);
        check({15'h0000, device_summary_bit}, 16'h0000);
        u_ctl.send(3, 16'h0000);
        check(device_event_mask, 16'h0000);
    endtask
    task automatic t_faults();
        logic [15:0] acc;
        acc = 16'h0000;
        for (int k = 0; k < 16; k++) begin
            if (k == 11) continue;
            pulse(ft, k);
            acc[k == 8 ? 1 : k] = 1'b1;
            u_ctl.send(2, 16'h0000);
            check(fault_status, acc);
        end
        u_ctl.send(2, 16'h0000);
        check(fault_status, acc);
    endtask
    task automatic t_clear();
        pulse(ev, 9);
        u_ctl.send(0, 16'h0000);
        u_ctl.send(1, 16'h0000);
        check(device_event_status, 16'h0000);
        u_ctl.send(2, 16'h0000);
        check(fault_status, 16'h0000);
        // Flash failure alone, so bit 1 cannot already be set
        pulse(ft, 8);
        u_ctl.send(2, 16'h0000);
        check(fault_status, 16'h0002);
    endtask
    task automatic t_reset();
        u_ctl.send(3, 16'hffff);
        pulse(ft, 2);
        pulse(ev, 7);
        rstn = 1'b0;
        repeat (4) @(negedge ref_clk);
        check(device_event_mask, 16'h0000);
        check({15'h0000, device_summary_bit}, 16'h0000);
        rstn = 1'b1;
        u_ctl.send(2, 16'h0000);
        check(fault_status, 16'h0000);
        u_ctl.send(1, 16'h0000);
        check(device_event_status, 16'h0000);
    endtask
    task automatic results();
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge ref_clk);
        rstn = 1'b1;
        t_latch();
        t_levels();
        t_starts();
        t_modes();
        t_summary();
        t_faults();
        t_clear();
        t_reset();
        results();
    end
    // Tests need well under 1000 cycles; allow ten times that
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
endmodule
bind des_status des_status_properties u_props (.*);

// [rtl/des_status.sv]
// Device event latch, event mask, summary bit and fault latch.
// Assumes all event inputs are one-cycle pulses or levels synchronous
// to ref_clk; command strobes come from the remote command decoder.
`timescale 1ns/1ps
module des_status
    import des_pkg::*;
(
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    // Measurement and comparator events (pulses)
    input  wire logic          compare_above,
    input  wire logic          compare_pass,
    input  wire logic          compare_under,
    input  wire logic          store_count_reached,
    input  wire logic          limiter_bottom,
    input  wire logic          limiter_top,
    input  wire logic          external_output_cut,
    input  wire logic          external_trigger_seen,
    input  wire logic          measure_start,
    input  wire logic          measure_done,
    input  wire logic          measure_readout,
    // Output state (levels)
    input  wire logic          paused_state,
    input  wire logic          output_active,
    input  wire logic          buffer_full_flag,
    // Calibration and sweep (pulses); hold and burst mode are levels
    input  wire logic          calibration_start,
    input  wire logic          calibration_done,
    input  wire logic          sequence_start,
    input  wire logic          sequence_finished,
    input  wire logic          step_start,
    input  wire logic          step_resume,
    input  wire logic          step_finished,
    input  wire logic          hold_trigger_mode,
    input  wire logic          burst_mode,
    // Fault events (pulses)
    input  wire logic          post_fail,
    input  wire logic          test_fail,
    input  wire logic          flash_fail,
    input  wire logic          cal_data_lost,
    input  wire logic          overload,
    input  wire logic          fan_stop,
    input  wire logic          overheat,
    input  wire logic          source_fault,
    input  wire logic          param_lost,
    input  wire logic          calc_error,
    input  wire logic          over_range,
    input  wire logic          cmd_arg_error,
    input  wire logic          cmd_exec_error,
    input  wire logic          cmd_format_error,
    input  wire logic          cmd_unknown,
    // Remote command strobes
    input  wire logic          clear_status,
    input  wire logic          device_event_status_rd,
    input  wire logic          fault_rd,
    input  wire logic          mask_wr,
    input  wire logic [15:0]   mask_wdata,
    // Readback
    output logic      [15:0]   device_event_status,
    output logic      [15:0]   fault_status,
    output logic      [15:0]   device_event_mask,
    output logic               device_summary_bit,
    output des_out_state_t     out_state
);

    logic [15:0]    ev_set;
    logic [15:0]    ev_clr;
    logic [15:0]    ev_bits;
    logic [15:0]    ft_set;
    logic [15:0]    ft_bits;
    logic [15:0]    next_mask;
    logic [15:0]    next_ev_rd;
    logic [15:0]    next_ft_rd;
    logic           hold_step;
    des_out_state_t next_state;

    assign hold_step = hold_trigger_mode && !burst_mode;

    always_comb begin
        ev_set = '0;
        ev_clr = '0;
        ev_set[EV_ABOVE] = compare_above;
        ev_set[EV_PASS]  = compare_pass;
        ev_set[EV_UNDER] = compare_under;
        ev_set[EV_STORE] = store_count_reached;
        ev_set[EV_PAUSED] = paused_state;
        ev_clr[EV_PAUSED] = !paused_state;
        ev_set[EV_ACTIVE] = output_active;
        ev_clr[EV_ACTIVE] = !output_active;
        ev_set[EV_LIM_BOT] = limiter_bottom;
        ev_set[EV_LIM_TOP] = limiter_top;
        ev_set[EV_EXT_CUT] = external_output_cut;
        ev_set[EV_EXT_TRIG] = external_trigger_seen;
        ev_set[EV_FULL] = buffer_full_flag;
        ev_clr[EV_FULL] = !buffer_full_flag;
        ev_set[EV_CAL] = calibration_done;
        ev_clr[EV_CAL] = calibration_start;
        ev_set[EV_SEQ] = sequence_finished;
        ev_clr[EV_SEQ] = sequence_start;
        ev_set[EV_STEP] = step_finished && hold_step;
        ev_clr[EV_STEP] = step_start || step_resume;
        ev_set[EV_MEAS] = measure_done;
        ev_clr[EV_MEAS] = measure_start || measure_readout;
        // Clear-status and read both clear only non-level bits; level
        // bits stay set while their condition holds and drop when it ends
        if (clear_status || device_event_status_rd) begin
            ev_clr = ev_clr | ~EV_LEVEL;
        end
    end

    // Event latch; level bits track their inputs
    des_sticky #(
        .W    (DES_W),
        .USED (EV_USED)
    ) u_events (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .set_bits (ev_set),
        .clr_bits (ev_clr),
        .bits     (ev_bits)
    );

    always_comb begin
        ft_set = '0;
        ft_set[FT_POST] = post_fail;
        ft_set[FT_TEST] = test_fail || flash_fail;
        ft_set[FT_CAL_LOST] = cal_data_lost;
        ft_set[FT_OVLD] = overload;
        ft_set[FT_FAN]  = fan_stop;
        ft_set[FT_HEAT] = overheat;
        ft_set[FT_SRC]      = source_fault;
        ft_set[FT_PAR_LOST] = param_lost;
        ft_set[FT_CALC]  = calc_error;
        ft_set[FT_RANGE] = over_range;
        ft_set[FT_ARG]     = cmd_arg_error;
        ft_set[FT_EXEC]    = cmd_exec_error;
        ft_set[FT_FMT]     = cmd_format_error;
        ft_set[FT_UNKNOWN] = cmd_unknown;
    end

    des_sticky #(
        .W    (DES_W),
        .USED (FT_USED)
    ) u_faults (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .set_bits (ft_set),
        .clr_bits ({DES_W{clear_status}}),
        .bits     (ft_bits)
    );

    always_comb begin
        next_mask = device_event_mask;
        if (mask_wr) begin
            next_mask = mask_wdata;
        end
        // Snapshot on query so the value read is the pre-clear one
        next_ev_rd = device_event_status;
        if (device_event_status_rd) begin
            next_ev_rd = ev_bits & EV_USED;
        end
        next_ft_rd = fault_status;
        if (fault_rd) begin
            next_ft_rd = ft_bits & FT_USED;
        end
        next_state = DES_IDLE;
        if (output_active) begin
            next_state = DES_ACTIVE;
        end else if (paused_state) begin
            next_state = DES_PAUSED;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            device_event_mask   <= RESET_WORD;
            device_event_status <= RESET_WORD;
            fault_status        <= RESET_WORD;
            device_summary_bit  <= 1'b0;
            out_state           <= DES_IDLE;
        end else begin
            device_event_mask   <= next_mask;
            device_event_status <= next_ev_rd;
            fault_status        <= next_ft_rd;
            device_summary_bit  <= |(ev_bits & device_event_mask);
            out_state           <= next_state;
        end
    end

endmodule

// [rtl/des_sticky.sv]
// Generic bank of sticky bits with per-bit set and clear.
// Assumes set and clear strobes synchronous to ref_clk.
`timescale 1ns/1ps
module des_sticky
    import des_pkg::*;
#(
    parameter int          W    = 16,
    parameter logic [15:0] USED = 16'hffff
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // Per-bit controls
    input  wire logic [W-1:0] set_bits,
    input  wire logic [W-1:0] clr_bits,
    // Stored value
    output logic      [W-1:0] bits
);

    logic [W-1:0] next_bits;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                // Set wins over clear so no event is lost
                if (!USED[i]) begin
                    next_bits[i] = 1'b0;
                end else if (set_bits[i]) begin
                    next_bits[i] = 1'b1;
                end else if (clr_bits[i]) begin
                    next_bits[i] = 1'b0;
                end else begin
                    next_bits[i] = bits[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            bits <= '0;
        end else begin
            bits <= next_bits;
        end
    end

endmodule

// [shared/des_pkg.sv]
// Constants for the device event and fault status block.
// Assumes a single 100 MHz clock and a remote controller front end
// that turns status queries and commands into one-cycle strobes.
// Behaviour
// - Comparator above, pass, under set bits 0-2
// - Store count reached sets bit 4
// - Bit 5 follows paused state
// - Bit 11 follows output active state
// - Limiter bottom/top set bits 6, 7
// - External output cut sets bit 8
// - External trigger seen sets bit 9
// - Bit 10 follows buffer full
// - Calibration done sets 12, start clears
// - Sequence finished sets 13, start clears
// - Hold-mode step done sets 14, start/resume clears (code sets 14 only with burst mode off)
// - Measure done sets 15, start/readout clears
// - Non-level events cleared: reset, clear-status, query read
// - Mask reset to zero, or written zero
// - Self-test failures set fault bits 0, 1
// - Calibration lost sets 2, power-cycle clears
// - Overload, fan, overheat latch bits 3-5
// - Source malfunction bit 6, params lost 7
// - Calculation error 9, over-range 10
// - Command errors set bits 12-15
// - Faults cleared by reset, clear-status only
// - Summary bit is masked event OR
package des_pkg;

    localparam int DES_W = 16;

    // Device event bit positions
    localparam int EV_ABOVE    = 0;
    localparam int EV_PASS     = 1;
    localparam int EV_UNDER    = 2;
    localparam int EV_STORE    = 4;
    localparam int EV_PAUSED   = 5;
    localparam int EV_LIM_BOT  = 6;
    localparam int EV_LIM_TOP  = 7;
    localparam int EV_EXT_CUT  = 8;
    localparam int EV_EXT_TRIG = 9;
    localparam int EV_FULL     = 10;
    localparam int EV_ACTIVE   = 11;
    localparam int EV_CAL      = 12;
    localparam int EV_SEQ      = 13;
    localparam int EV_STEP     = 14;
    localparam int EV_MEAS     = 15;

    // Fault bit positions
    localparam int FT_POST     = 0;
    localparam int FT_TEST     = 1;
    localparam int FT_CAL_LOST = 2;
    localparam int FT_OVLD     = 3;
    localparam int FT_FAN      = 4;
    localparam int FT_HEAT     = 5;
    localparam int FT_SRC      = 6;
    localparam int FT_PAR_LOST = 7;
    localparam int FT_CALC     = 9;
    localparam int FT_RANGE    = 10;
    localparam int FT_ARG      = 12;
    localparam int FT_EXEC     = 13;
    localparam int FT_FMT      = 14;
    localparam int FT_UNKNOWN  = 15;

    // Bits that exist; others read zero
    localparam logic [15:0] EV_USED    = 16'hfff7;
    localparam logic [15:0] FT_USED    = 16'hf6ff;
    localparam logic [15:0] EV_LEVEL   = 16'h0c20;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam int          SUMMARY_BIT = 3;

    typedef enum logic [1:0] {
        DES_IDLE,
        DES_ACTIVE,
        DES_PAUSED
    } des_out_state_t;

endpackage
